// [include/sensor_packer_pkg.sv]
// ==========================================================
// shared constants of the sensor output packer
package sensor_packer_pkg;

	// unit population and image geometry
	localparam int unsigned UNIT_COUNT = 30;
	localparam int unsigned IMAGE_BITS = 64;
	localparam int unsigned BYTE_COUNT = 8;
	localparam int unsigned WORD_COUNT = 4;
	localparam int unsigned USED_BITS = 2 * UNIT_COUNT;

	// object dictionary indices
	localparam logic [15:0] IDX_BYTE_IMAGE = 16'h6000;
	localparam logic [15:0] IDX_WORD_IMAGE = 16'h6100;

	// subindex of the entry counts, first data subindex
	localparam logic [7:0] SUB_COUNT = 8'h00;
	localparam logic [7:0] SUB_FIRST = 8'h01;

	// entry count values after reset and forever
	localparam logic [7:0] BYTE_ENTRY_COUNT = 8'h08;
	localparam logic [7:0] WORD_ENTRY_COUNT = 8'h04;

	// broadcast setting field layout
	localparam int unsigned BC_VALUE_LSB = 0;
	localparam int unsigned BC_VALUE_MSB = 31;
	localparam int unsigned BC_SEL_LSB = 32;
	localparam int unsigned BC_SEL_MSB = 61;
	localparam int unsigned BC_PAD_LSB = 62;
	localparam int unsigned BC_PAD_MSB = 63;

	// values after reset, plus the all-units selection UNIT_ALL
	localparam logic [63:0] IMAGE_RESET = 64'h0000_0000_0000_0000;
	localparam logic [15:0] RDATA_RESET = 16'h0000;
	localparam logic [29:0] UNIT_NONE = 30'h0000_0000;
	localparam logic [29:0] UNIT_ALL = 30'h3fff_ffff;
	localparam logic [31:0] VALUE_RESET = 32'h0000_0000;

endpackage : sensor_packer_pkg

// [verilog/broadcast_decoder.sv]
`timescale 1ns/1ps
// ==========================================================
// decodes a 64-bit broadcast setting into per-unit write strobes
module broadcast_decoder (
	input wire logic clk_sys_i,
	input wire logic rst_i,
	input wire logic bc_wr_i,
	input wire logic [63:0] bc_data_i,
	output logic [29:0] unit_wr_o,
	output logic [31:0] unit_val_o,
	output logic bc_err_o
);
	import sensor_packer_pkg::*;

	logic [29:0] next_unit_wr;
	logic [31:0] next_unit_val;
	logic next_bc_err;
	logic [29:0] sel;
	logic [1:0] pad;

	// ==========================================================
	// field split and target selection
	always_comb begin
		sel = bc_data_i[BC_SEL_MSB:BC_SEL_LSB];
		pad = bc_data_i[BC_PAD_MSB:BC_PAD_LSB];
		next_unit_wr = UNIT_NONE;
		next_unit_val = unit_val_o;
		next_bc_err = 1'b0;
		if (bc_wr_i) begin
			if (pad != 2'h0) begin
				// nonzero unused bits: drop the write
				next_bc_err = 1'b1;
			end else begin
				next_unit_val = bc_data_i[BC_VALUE_MSB:BC_VALUE_LSB];
				if (sel == UNIT_NONE || sel == UNIT_ALL) begin
					next_unit_wr = UNIT_ALL;
				end else begin
					next_unit_wr = sel;
				end
			end
		end
	end

	// ==========================================================
	// registered strobes and value
	always_ff @(posedge clk_sys_i or posedge rst_i) begin
		if (rst_i) begin
			unit_wr_o <= UNIT_NONE;
			unit_val_o <= VALUE_RESET;
			bc_err_o <= 1'b0;
		end else begin
			unit_wr_o <= next_unit_wr;
			unit_val_o <= next_unit_val;
			bc_err_o <= next_bc_err;
		end
	end

endmodule : broadcast_decoder

// [verilog/sensor_output_bit_packer.sv]
`timescale 1ns/1ps
// ==========================================================
// packs sensor switching outputs into byte and word images
module sensor_output_bit_packer (
	input wire logic clk_sys_i,
	input wire logic rst_i,
	// switching outputs from the amplifiers, asynchronous
	input wire logic [29:0] sens_out1_i,
	input wire logic [29:0] sens_out2_i,
	// unit kind: high when the unit has switching outputs
	input wire logic [29:0] unit_has_switch_i,
	// object read port
	input wire logic rd_i,
	input wire logic [15:0] rd_index_i,
	input wire logic [7:0] rd_subindex_i,
	output logic [15:0] rd_data_o,
	output logic rd_valid_o,
	output logic rd_err_o,
	output logic rd_mappable_o,
	// write attempt on the read-only objects
	input wire logic wr_i,
	input wire logic [15:0] wr_index_i,
	output logic wr_refused_o,
	// cyclic process image
	output logic [63:0] pdo_image_o,
	// broadcast setting write
	input wire logic bc_wr_i,
	input wire logic [63:0] bc_data_i,
	output logic [29:0] unit_wr_o,
	output logic [31:0] unit_val_o,
	output logic bc_err_o
);
	import sensor_packer_pkg::*;

	// ==========================================================
	// functions

	// packs two outputs per unit, unused tail held at zero
	function automatic logic [63:0] pack_image(
		input logic [29:0] o1,
		input logic [29:0] o2,
		input logic [29:0] has_sw
	);
		logic [63:0] img;
		img = IMAGE_RESET;
		for (int u = 0; u < UNIT_COUNT; u++) begin
			img[2 * u] = o1[u] & has_sw[u];
			img[2 * u + 1] = o2[u] & has_sw[u];
		end
		return img;
	endfunction : pack_image

	// true when the index names one of the two image objects
	function automatic logic is_image_index(input logic [15:0] idx);
		return (idx == IDX_BYTE_IMAGE) || (idx == IDX_WORD_IMAGE);
	endfunction : is_image_index

	// ==========================================================
	// input synchronisers

	logic [29:0] out1_sync_a;
	logic [29:0] out1_sync_b;
	logic [29:0] out2_sync_a;
	logic [29:0] out2_sync_b;

	// two flops per switching output pin before any logic looks at it
	always_ff @(posedge clk_sys_i or posedge rst_i) begin
		if (rst_i) begin
			out1_sync_a <= UNIT_NONE;
			out1_sync_b <= UNIT_NONE;
			out2_sync_a <= UNIT_NONE;
			out2_sync_b <= UNIT_NONE;
		end else begin
			out1_sync_a <= sens_out1_i;
			out1_sync_b <= out1_sync_a;
			out2_sync_a <= sens_out2_i;
			out2_sync_b <= out2_sync_a;
		end
	end

	// ==========================================================
	// packed image

	logic [63:0] next_image;

	// rebuilt every cycle from the synchronised outputs
	always_comb begin
		next_image = pack_image(out1_sync_b, out2_sync_b, unit_has_switch_i);
		next_image[IMAGE_BITS - 1:USED_BITS] = '0;
	end

	// image feeds both the cyclic output and the reads
	always_ff @(posedge clk_sys_i or posedge rst_i) begin
		if (rst_i) begin
			pdo_image_o <= IMAGE_RESET;
		end else begin
			pdo_image_o <= next_image;
		end
	end

	// ==========================================================
	// object registers

	logic [7:0] input_byte_entry_count;
	logic [7:0] input_word_entry_count;
	logic [7:0] packed_input_bytes [BYTE_COUNT];
	logic [15:0] packed_input_words [WORD_COUNT];

	// entry counts are fixed, never part of the cyclic image
	always_comb begin
		input_byte_entry_count = BYTE_ENTRY_COUNT;
		input_word_entry_count = WORD_ENTRY_COUNT;
	end

	// byte entries cut from the registered image
	always_comb begin
		for (int n = 0; n < BYTE_COUNT; n++) begin
			packed_input_bytes[n] = pdo_image_o[8 * n +: 8];
		end
	end

	// word entries cut from the same image, so both views agree
	always_comb begin
		for (int n = 0; n < WORD_COUNT; n++) begin
			packed_input_words[n] = pdo_image_o[16 * n +: 16];
		end
	end

	// ==========================================================
	// object read decode

	logic [15:0] next_rd_data;
	logic next_rd_valid;
	logic next_rd_err;
	logic next_rd_mappable;
	logic [2:0] byte_sel;
	logic [1:0] word_sel;
	logic [7:0] sub_off;

	// subindex 0 gives the count, 1..n give the data entries
	always_comb begin
		next_rd_data = RDATA_RESET;
		next_rd_valid = 1'b0;
		next_rd_err = 1'b0;
		next_rd_mappable = 1'b0;
		sub_off = rd_subindex_i - SUB_FIRST;
		byte_sel = sub_off[2:0];
		word_sel = sub_off[1:0];
		if (rd_i) begin
			if (rd_index_i == IDX_BYTE_IMAGE) begin
				if (rd_subindex_i == SUB_COUNT) begin
					next_rd_data = {8'h00, input_byte_entry_count};
					next_rd_valid = 1'b1;
					next_rd_mappable = 1'b0;
				end else if (rd_subindex_i <= BYTE_ENTRY_COUNT) begin
					// bytes numbered one to eight, upper lane zero
					next_rd_data = {8'h00, packed_input_bytes[byte_sel]};
					next_rd_valid = 1'b1;
					next_rd_mappable = 1'b1;
				end else begin
					next_rd_err = 1'b1;
				end
			end else if (rd_index_i == IDX_WORD_IMAGE) begin
				if (rd_subindex_i == SUB_COUNT) begin
					next_rd_data = {8'h00, input_word_entry_count};
					next_rd_valid = 1'b1;
					next_rd_mappable = 1'b0;
				end else if (rd_subindex_i <= WORD_ENTRY_COUNT) begin
					// same bits as the byte image, 16 at a time
					next_rd_data = packed_input_words[word_sel];
					next_rd_valid = 1'b1;
					next_rd_mappable = 1'b1;
				end else begin
					next_rd_err = 1'b1;
				end
			end else begin
				// unknown object
				next_rd_err = 1'b1;
			end
		end
	end

	// read answer registered one cycle after the request
	always_ff @(posedge clk_sys_i or posedge rst_i) begin
		if (rst_i) begin
			rd_data_o <= RDATA_RESET;
			rd_valid_o <= 1'b0;
			rd_err_o <= 1'b0;
			rd_mappable_o <= 1'b0;
		end else begin
			rd_data_o <= next_rd_data;
			rd_valid_o <= next_rd_valid;
			rd_err_o <= next_rd_err;
			rd_mappable_o <= next_rd_mappable;
		end
	end

	// ==========================================================
	// write refusal on the read-only objects

	logic next_wr_refused;

	// counts and data entries alike are read-only
	always_comb begin
		next_wr_refused = wr_i && is_image_index(wr_index_i);
	end

	// refusal pulse, image untouched
	always_ff @(posedge clk_sys_i or posedge rst_i) begin
		if (rst_i) begin
			wr_refused_o <= 1'b0;
		end else begin
			wr_refused_o <= next_wr_refused;
		end
	end

	// ==========================================================
	// broadcast setting decode

	// strobes and value come from flops inside the decoder
	broadcast_decoder u_bc (
		.clk_sys_i(clk_sys_i),
		.rst_i(rst_i),
		.bc_wr_i(bc_wr_i),
		.bc_data_i(bc_data_i),
		.unit_wr_o(unit_wr_o),
		.unit_val_o(unit_val_o),
		.bc_err_o(bc_err_o)
	);

endmodule : sensor_output_bit_packer

// [verification/master_model.sv]
`timescale 1ns/1ps
// ==========================================================
// fieldbus master reading object entries
module master_model (
	input wire logic clk_sys_i,
	output logic rd_o,
	output logic [15:0] idx_o,
	output logic [7:0] sub_o
);
	// idle request lines at time zero
	initial begin
		rd_o = 1'b0;
		idx_o = 16'h0000;
		sub_o = 8'h00;
	end
	// hold request over the taking edge, then release to inverse values
	task read(input logic [15:0] idx, input logic [7:0] sub);
		@(negedge clk_sys_i);
		rd_o = 1'b1;
		idx_o = idx;
		sub_o = sub;
		@(negedge clk_sys_i);
		rd_o = 1'b0;
		idx_o = ~idx;
		sub_o = ~sub;
	endtask : read
endmodule : master_model

// [verification/packer_assertions.sv]
`timescale 1ns/1ps
// ==========================================================
// port checker of the packer
module packer_checker (
	input wire logic clk_sys_i,
	input wire logic rst_i,
	input wire logic [29:0] unit_has_switch_i,
	input wire logic rd_i,
	input wire logic [15:0] rd_index_i,
	input wire logic [7:0] rd_subindex_i,
	input wire logic [15:0] rd_data_o,
	input wire logic rd_valid_o,
	input wire logic rd_mappable_o,
	input wire logic [63:0] pdo_image_o,
	input wire logic bc_wr_i,
	input wire logic [63:0] bc_data_i,
	input wire logic [29:0] unit_wr_o,
	input wire logic [31:0] unit_val_o,
	input wire logic bc_err_o
);
	import sensor_packer_pkg::*;
	logic rd_b;
	logic rd_w;
	logic bc_ok;
	default clocking @(posedge clk_sys_i); endclocking
	default disable iff (rst_i);
	// read request decode per object
	assign rd_b = rd_i && rd_index_i == IDX_BYTE_IMAGE;
	assign rd_w = rd_i && rd_index_i == IDX_WORD_IMAGE;
	assign bc_ok = bc_wr_i && bc_data_i[63:62] == 2'b00;
	count_byte_a: assert property (
		rd_b && rd_subindex_i == 8'h00 |=> rd_valid_o && rd_data_o == 16'h0008 && !rd_mappable_o)
		else $error("byte entry count wrong");
	count_word_a: assert property (
		rd_w && rd_subindex_i == 8'h00 |=> rd_valid_o && rd_data_o == 16'h0004 && !rd_mappable_o)
		else $error("word entry count wrong");
	byte_tail_a: assert property (
		rd_b && rd_subindex_i == 8'h08 |=> rd_data_o[15:4] == 12'h000 && rd_mappable_o)
		else $error("last byte upper bits not clear");
	word_tail_a: assert property (
		rd_w && rd_subindex_i == 8'h04 |=> rd_data_o[15:12] == 4'h0 && rd_mappable_o)
		else $error("last word upper bits not clear");
	image_pad_a: assert property (pdo_image_o[63:60] == 4'h0)
		else $error("image padding not zero");
	bc_pad_a: assert property (
		bc_wr_i && bc_data_i[63:62] != 2'b00 |=> bc_err_o && unit_wr_o == 30'h0000_0000)
		else $error("padded broadcast not dropped");
	bc_all_a: assert property (
		bc_ok && bc_data_i[61:32] == 30'h0 |=> unit_wr_o == UNIT_ALL && unit_val_o == $past(bc_data_i[31:0]))
		else $error("broadcast to all units wrong");
	bc_select_a: assert property (
		bc_ok && bc_data_i[61:32] != 30'h0 |=> unit_wr_o == $past(bc_data_i[61:32]) && !bc_err_o)
		else $error("broadcast strobes differ from selection");
	no_switch_a: assert property (
		!unit_has_switch_i[29] [*3] |-> pdo_image_o[59:58] == 2'b00)
		else $error("unit without outputs shows bits");
endmodule : packer_checker
bind sensor_output_bit_packer packer_checker chk_u (.clk_sys_i, .rst_i, .unit_has_switch_i,
	.rd_i, .rd_index_i, .rd_subindex_i, .rd_data_o, .rd_valid_o, .rd_mappable_o, .pdo_image_o,
	.bc_wr_i, .bc_data_i, .unit_wr_o, .unit_val_o, .bc_err_o);

// [verification/testbench.sv]
`timescale 1ns/1ps
// ==========================================================
// bench of the sensor output packer
module testbench;
	import sensor_packer_pkg::*;
	typedef struct packed {logic [15:0] idx; logic [7:0] sub; logic [15:0] data; logic err;} row_t;
	logic clk_sys_i, rst_i, wr_i, bc_wr_i, rd_valid_o, rd_err_o, rd_mappable_o;
	logic wr_refused_o, bc_err_o;
	logic [29:0] sens_out1_i, sens_out2_i, unit_has_switch_i, unit_wr_o;
	logic [15:0] wr_index_i, rd_data_o;
	logic [63:0] bc_data_i, pdo_image_o;
	logic [31:0] unit_val_o;
	wire rd_i;
	wire [15:0] rd_index_i;
	wire [7:0] rd_subindex_i;
	int num_errors = 0;
	int checked = 0;
	// reads of image 0x0555_5555_5555_5555
	row_t rows[8] = '{{16'h6000, 8'h00, 16'h0008, 1'b0}, {16'h6000, 8'h01, 16'h0055, 1'b0},
		{16'h6000, 8'h08, 16'h0005, 1'b0}, {16'h6100, 8'h00, 16'h0004, 1'b0},
		{16'h6100, 8'h01, 16'h5555, 1'b0}, {16'h6100, 8'h04, 16'h0555, 1'b0},
		{16'h6000, 8'h09, 16'h0000, 1'b1}, {16'h6200, 8'h01, 16'h0000, 1'b1}};
	sensor_output_bit_packer dut_u (.clk_sys_i, .rst_i, .sens_out1_i, .sens_out2_i,
		.unit_has_switch_i, .rd_i, .rd_index_i, .rd_subindex_i, .rd_data_o, .rd_valid_o,
		.rd_err_o, .rd_mappable_o, .wr_i, .wr_index_i, .wr_refused_o, .pdo_image_o, .bc_wr_i,
		.bc_data_i, .unit_wr_o, .unit_val_o, .bc_err_o);
	master_model master_u (.clk_sys_i, .rd_o(rd_i), .idx_o(rd_index_i), .sub_o(rd_subindex_i));
	task check(input logic [63:0] seen, input logic [63:0] exp);
		checked++;
		if (seen !== exp) begin
			$display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
			num_errors++;
		end
	endtask : check
	task report_and_stop;
		$display("errors %0d checks %0d", num_errors, checked);
		if (num_errors == 0 && checked > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask : report_and_stop
	// drive pins, wait for sync and image flop
	task pins(input logic [29:0] o1, input logic [29:0] o2, input logic [29:0] hs);
		@(negedge clk_sys_i);
		sens_out1_i = o1;
		sens_out2_i = o2;
		unit_has_switch_i = hs;
		repeat (4) @(negedge clk_sys_i);
	endtask : pins
	// one broadcast, then strobe and error checked
	task bcast(input logic [63:0] d, input logic [29:0] ewr, input logic [31:0] ev);
		@(negedge clk_sys_i);
		bc_wr_i = 1'b1;
		bc_data_i = d;
		@(negedge clk_sys_i);
		bc_wr_i = 1'b0;
		check(unit_wr_o, ewr);
		check(unit_val_o, ev);
		check(bc_err_o, d[63:62] != 2'b00);
	endtask : bcast
	// one write attempt, refusal pulse checked
	task poke(input logic [15:0] idx, input logic exp);
		@(negedge clk_sys_i);
		wr_i = 1'b1;
		wr_index_i = idx;
		@(negedge clk_sys_i);
		wr_i = 1'b0;
		check(wr_refused_o, exp);
	endtask : poke
	// clock
	initial begin
		clk_sys_i = 1'b0;
		forever #50 clk_sys_i = ~clk_sys_i;
	end
	// watchdog
	initial begin
		#50000;
		num_errors++;
		report_and_stop;
	end
	// main sequence
	initial begin
		{rst_i, wr_i, bc_wr_i, wr_index_i, bc_data_i} = {1'b1, 82'h0};
		{sens_out1_i, sens_out2_i, unit_has_switch_i} = 90'h0;
		repeat (20) @(negedge clk_sys_i);
		rst_i = 1'b0;
		check(pdo_image_o, IMAGE_RESET);
		pins(UNIT_ALL, UNIT_NONE, UNIT_ALL);
		foreach (rows[i]) begin
			master_u.read(rows[i].idx, rows[i].sub);
			check(rd_data_o, rows[i].data);
			check(rd_valid_o, !rows[i].err);
			check(rd_err_o, rows[i].err);
			check(rd_mappable_o, rows[i].sub != 8'h00 && !rows[i].err);
		end
		// output 2 of every unit only
		pins(UNIT_NONE, UNIT_ALL, UNIT_ALL);
		master_u.read(IDX_WORD_IMAGE, 8'h04);
		check(rd_data_o, 16'h0aaa);
		// unit 30 has no switching outputs
		pins(UNIT_ALL, UNIT_ALL, 30'h1fff_ffff);
		check(pdo_image_o, 64'h03ff_ffff_ffff_ffff);
		master_u.read(IDX_BYTE_IMAGE, 8'h08);
		check(rd_data_o, 16'h0003);
		poke(IDX_BYTE_IMAGE, 1'b1);
		poke(IDX_WORD_IMAGE, 1'b1);
		poke(16'h4f04, 1'b0);
		bcast(64'h2000_0201_0000_03e8, 30'h2000_0201, 32'h0000_03e8);
		bcast(64'h0000_0000_0000_0001, UNIT_ALL, 32'h0000_0001);
		bcast(64'h3fff_ffff_0000_0002, UNIT_ALL, 32'h0000_0002);
		bcast(64'hc000_0001_0000_0055, UNIT_NONE, 32'h0000_0002);
		// mid-run reset clears image and value, pins return after three edges
		@(negedge clk_sys_i);
		rst_i = 1'b1;
		@(negedge clk_sys_i);
		check(pdo_image_o, IMAGE_RESET);
		check(unit_val_o, VALUE_RESET);
		rst_i = 1'b0;
		@(negedge clk_sys_i);
		check(pdo_image_o, IMAGE_RESET);
		repeat (2) @(negedge clk_sys_i);
		check(pdo_image_o, 64'h03ff_ffff_ffff_ffff);
		report_and_stop;
	end
endmodule : testbench
